// ### hw/pm_cap_regs.sv
// Power-management capability and control/status registers, AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "pm_regs_defs.svh"
module pm_cap_regs (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic hot_reset,
  input wire logic cfg_unlock,
  input wire logic is_upstream,
  input wire logic own_wake,
  output logic wake_msg,
  output logic hot_off_state,
  output logic context_kept
);
  pm_regs_pkg::top_state_type s_reg;
  pm_regs_pkg::top_state_type s_next;
  pm_ctl_if ctl ();
  logic do_wr;
  logic [31:0] cap_merged;

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  function automatic logic reg_hit(input logic [11:0] a,
                                   input logic [11:0] off);
    reg_hit = ({a[11:2], 2'b00} == off);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = m;
  endfunction

  function automatic logic [31:0] cap_word(input logic [2:0] aux,
                                           input logic [4:0] wsup);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`AUX_MSB:`AUX_LSB] = aux;
    w[`D1_BIT] = `D1_SUP;
    w[`D2_BIT] = `D2_SUP;
    w[`WSUP_MSB:`WSUP_LSB] = wsup;
    cap_word = w;
  endfunction

  function automatic logic [31:0] csr_word(input logic [1:0] ps,
                                           input logic ctx,
                                           input logic wen,
                                           input logic wst);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`PS_MSB:`PS_LSB] = ps;
    w[`CTX_BIT] = ctx;
    w[`WEN_BIT] = wen;
    w[`POWER_DATA_SELECT_MSB:`POWER_DATA_SELECT_LSB] = `POWER_DATA_SELECT_VAL;
    w[`POWER_DATA_SCALE_MSB:`POWER_DATA_SCALE_LSB] = `POWER_DATA_SCALE_VAL;
    w[`WST_BIT] = wst;
    w[`BUS_STATE_SUPPORT_BIT] = `BUS_STATE_SUPPORT_VAL;
    w[`BUS_POWER_CLOCK_CTL_EN_BIT] = `BUS_POWER_CLOCK_CTL_EN_VAL;
    w[`DATA_MSB:`DATA_LSB] = `DATA_VAL;
    csr_word = w;
  endfunction

  // -------------------------------------------------------------------
  // Sub-blocks
  // -------------------------------------------------------------------
  pm_state_ctl u_state (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ctl(ctl.state_side)
  );

  wake_ctl u_wake (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ctl(ctl.wake_side)
  );

  assign do_wr = s_reg.aw_held && s_reg.w_held && !s_reg.b_valid;
  assign cap_merged = merge(cap_word(s_reg.aux_current_need,
                                     s_reg.wake_support),
                            s_reg.w_data, s_reg.w_strb);

  assign ctl.csr_wr = do_wr && reg_hit(s_reg.aw_addr, `PM_CSR_OFF);
  assign ctl.csr_wdata = merge(csr_word(ctl.power_state_sel,
                                        ctl.context_kept_flag,
                                        ctl.wake_enable,
                                        ctl.wake_status),
                               s_reg.w_data, s_reg.w_strb);
  assign ctl.csr_w1c = s_reg.w_data[`WST_BIT] && s_reg.w_strb[`WST_BYTE];
  assign ctl.hot_reset = hot_reset;
  assign ctl.cfg_unlock = cfg_unlock;
  assign ctl.own_wake = own_wake;
  assign ctl.is_upstream = is_upstream;

  // -------------------------------------------------------------------
  // Bus slave and sticky capability fields
  // -------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (awvalid && !s_reg.aw_held) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && !s_reg.w_held) begin
      s_next.w_held = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (s_reg.b_valid && bready) begin
      s_next.b_valid = 1'b0;
    end
    if (do_wr) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.b_valid = 1'b1;
      s_next.b_resp = `RESP_SLVERR;
      if (reg_hit(s_reg.aw_addr, `PM_CSR_OFF)) begin
        s_next.b_resp = `RESP_OKAY;
      end
      if (reg_hit(s_reg.aw_addr, `PM_CAP_OFF)) begin
        s_next.b_resp = `RESP_OKAY;
        // Sticky fields, untouched by hot reset
        s_next.aux_current_need = cap_merged[`AUX_MSB:`AUX_LSB];
        s_next.wake_support = cap_merged[`WSUP_MSB:`WSUP_LSB];
      end
    end
    if (s_reg.r_valid && rready) begin
      s_next.r_valid = 1'b0;
    end
    if (arvalid && !s_reg.r_valid) begin
      s_next.r_valid = 1'b1;
      s_next.r_data = 32'h0000_0000;
      s_next.r_resp = `RESP_SLVERR;
      if (reg_hit(araddr, `PM_CAP_OFF)) begin
        s_next.r_data = cap_word(s_reg.aux_current_need,
                                 s_reg.wake_support);
        s_next.r_resp = `RESP_OKAY;
      end
      if (reg_hit(araddr, `PM_CSR_OFF)) begin
        s_next.r_data = csr_word(ctl.power_state_sel, ctl.context_kept_flag,
                                 ctl.wake_enable, ctl.wake_status);
        s_next.r_resp = `RESP_OKAY;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.aux_current_need <= `AUX_RST;
      s_reg.wake_support <= `WSUP_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  assign awready = !s_reg.aw_held;
  assign wready = !s_reg.w_held;
  assign bvalid = s_reg.b_valid;
  assign bresp = s_reg.b_resp;
  assign arready = !s_reg.r_valid;
  assign rvalid = s_reg.r_valid;
  assign rdata = s_reg.r_data;
  assign rresp = s_reg.r_resp;
  assign wake_msg = ctl.wake_msg;
  assign hot_off_state = (ctl.power_state_sel == pm_regs_pkg::ps_hot_off);
  assign context_kept = ctl.context_kept_flag;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  property p_aux_hot;
    @(posedge core_clk) disable iff (!rst_b)
    !do_wr |=> $stable(s_reg.aux_current_need)
               && $stable(s_reg.wake_support);
  endproperty
  a_aux_hot: assert property (p_aux_hot)
    else $error("sticky capability field changed without a write");

  property p_cap_zero;
    @(posedge core_clk) disable iff (!rst_b)
    arvalid && !s_reg.r_valid && reg_hit(araddr, `PM_CAP_OFF)
    |=> rvalid && rdata[`D2_BIT:`D1_BIT] == 2'h0
        && rdata[21:0] == 22'h000000;
  endproperty
  a_cap_zero: assert property (p_cap_zero)
    else $error("unsupported state bits read as one");

  property p_csr_zero;
    @(posedge core_clk) disable iff (!rst_b)
    arvalid && !s_reg.r_valid && reg_hit(araddr, `PM_CSR_OFF)
    |=> rvalid && rdata[`DATA_MSB:`DATA_LSB] == 8'h00
        && rdata[`BUS_POWER_CLOCK_CTL_EN_BIT:`BUS_STATE_SUPPORT_BIT] == 2'h0
        && rdata[`POWER_DATA_SCALE_MSB:`POWER_DATA_SELECT_LSB] == 6'h00;
  endproperty
  a_csr_zero: assert property (p_csr_zero)
    else $error("unimplemented field read as non-zero");

  property p_wr_resp;
    @(posedge core_clk) disable iff (!rst_b)
    do_wr |=> bvalid && awready && wready;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response not raised one cycle after write");

  property p_unmapped_wr;
    @(posedge core_clk) disable iff (!rst_b)
    do_wr && !reg_hit(s_reg.aw_addr, `PM_CSR_OFF)
    && !reg_hit(s_reg.aw_addr, `PM_CAP_OFF)
    |=> bresp == `RESP_SLVERR && $stable(s_reg.aux_current_need)
        && $stable(s_reg.wake_support);
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr)
    else $error("unmapped write not refused");

  property p_unmapped_rd;
    @(posedge core_clk) disable iff (!rst_b)
    arvalid && !s_reg.r_valid && !reg_hit(araddr, `PM_CSR_OFF)
    && !reg_hit(araddr, `PM_CAP_OFF)
    |=> rvalid && rresp == `RESP_SLVERR && rdata == 32'h0000_0000;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd)
    else $error("unmapped read not refused");

  property p_hot_reset_out;
    @(posedge core_clk) disable iff (!rst_b)
    hot_reset |=> context_kept && !hot_off_state;
  endproperty
  a_hot_reset_out: assert property (p_hot_reset_out)
    else $error("hot reset did not restore power state and context flag");

  property p_csr_wake_read;
    @(posedge core_clk) disable iff (!rst_b)
    arvalid && !s_reg.r_valid && reg_hit(araddr, `PM_CSR_OFF)
    |=> rdata[`WST_BIT] == $past(ctl.wake_status)
        && rdata[`WEN_BIT] == $past(ctl.wake_enable);
  endproperty
  a_csr_wake_read: assert property (p_csr_wake_read)
    else $error("wake bits read back wrong");
endmodule

// ### hw/pm_regs_defs.svh
// Offsets, field positions and reset values of the power-management registers
`ifndef PM_REGS_DEFS_SVH
`define PM_REGS_DEFS_SVH
`define PM_CAP_OFF 12'h0c0
`define PM_CSR_OFF 12'h0c4
`define AUX_LSB 22
`define AUX_MSB 24
`define D1_BIT 25
`define D2_BIT 26
`define WSUP_LSB 27
`define WSUP_MSB 31
`define PS_LSB 0
`define PS_MSB 1
`define CTX_BIT 3
`define WEN_BIT 8
`define WST_BIT 15
`define WST_BYTE 1
`define POWER_DATA_SELECT_LSB 9
`define POWER_DATA_SELECT_MSB 12
`define POWER_DATA_SCALE_LSB 13
`define POWER_DATA_SCALE_MSB 14
`define BUS_STATE_SUPPORT_BIT 22
`define BUS_POWER_CLOCK_CTL_EN_BIT 23
`define DATA_LSB 24
`define DATA_MSB 31
`define AUX_RST 3'h7
`define WSUP_RST 5'h19
`define PS_RST 2'h0
`define CTX_RST 1'h1
`define WEN_RST 1'h0
`define WST_RST 1'h0
`define D1_SUP 1'h0
`define D2_SUP 1'h0
`define POWER_DATA_SELECT_VAL 4'h0
`define POWER_DATA_SCALE_VAL 2'h0
`define BUS_STATE_SUPPORT_VAL 1'h0
`define BUS_POWER_CLOCK_CTL_EN_VAL 1'h0
`define DATA_VAL 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### hw/pm_regs_pkg.sv
// Types shared by the power-management register block
package pm_regs_pkg;
  typedef enum logic [1:0] {
    ps_active = 2'h0,
    ps_hot_off = 2'h3
  } power_state_type;

  typedef struct packed {
    power_state_type power_state_sel;
    logic context_kept_flag;
  } power_state_sel_state_type;

  typedef struct packed {
    logic wake_enable;
    logic wake_status;
    logic wake_msg;
  } wake_state_type;

  typedef struct packed {
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic [2:0] aux_current_need;
    logic [4:0] wake_support;
  } top_state_type;
endpackage

// ### hw/pm_ctl_if.sv
// Control path from the register front end to the state holders
`timescale 1ns/100ps
interface pm_ctl_if;
  logic csr_wr;
  logic [31:0] csr_wdata;
  logic csr_w1c;
  logic hot_reset;
  logic cfg_unlock;
  logic own_wake;
  logic is_upstream;
  pm_regs_pkg::power_state_type power_state_sel;
  logic context_kept_flag;
  logic wake_enable;
  logic wake_status;
  logic wake_msg;

  modport hub (
    output csr_wr, csr_wdata, csr_w1c, hot_reset, cfg_unlock, own_wake,
    output is_upstream,
    input power_state_sel, context_kept_flag, wake_enable, wake_status,
    input wake_msg
  );
  modport state_side (
    input csr_wr, csr_wdata, hot_reset, cfg_unlock,
    output power_state_sel, context_kept_flag
  );
  modport wake_side (
    input csr_wr, csr_wdata, csr_w1c, hot_reset, own_wake, is_upstream,
    output wake_enable, wake_status, wake_msg
  );
endinterface

// ### hw/pm_state_ctl.sv
// Power state and context-kept flag holder
`timescale 1ns/100ps
`include "pm_regs_defs.svh"
module pm_state_ctl (
  input wire logic core_clk,
  input wire logic rst_b,
  pm_ctl_if.state_side ctl
);
  pm_regs_pkg::power_state_sel_state_type s_reg;
  pm_regs_pkg::power_state_sel_state_type s_next;
  logic [1:0] ps_wr;

  assign ps_wr = ctl.csr_wdata[`PS_MSB:`PS_LSB];

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (ctl.hot_reset) begin
      s_next.power_state_sel = pm_regs_pkg::power_state_type'(`PS_RST);
      s_next.context_kept_flag = `CTX_RST;
    end else if (ctl.csr_wr) begin
      if (ps_wr == `PS_RST || ps_wr == 2'h3) begin
        s_next.power_state_sel = pm_regs_pkg::power_state_type'(ps_wr);
      end
      // Reserved encodings leave the state alone
      if (ctl.cfg_unlock) begin
        s_next.context_kept_flag = ctl.csr_wdata[`CTX_BIT];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg.power_state_sel <= pm_regs_pkg::power_state_type'(`PS_RST);
      s_reg.context_kept_flag <= `CTX_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ctl.power_state_sel = s_reg.power_state_sel;
  assign ctl.context_kept_flag = s_reg.context_kept_flag;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  property p_ps_legal;
    @(posedge core_clk) disable iff (!rst_b)
    s_reg.power_state_sel == 2'h0 || s_reg.power_state_sel == 2'h3;
  endproperty
  a_ps_legal: assert property (p_ps_legal)
    else $error("power state holds a reserved code");

  property p_ps_keep;
    @(posedge core_clk) disable iff (!rst_b)
    ctl.csr_wr && !ctl.hot_reset && (ps_wr == 2'h1 || ps_wr == 2'h2)
    |=> $stable(s_reg.power_state_sel);
  endproperty
  a_ps_keep: assert property (p_ps_keep)
    else $error("reserved write changed the power state");

  property p_ps_hot_off;
    @(posedge core_clk) disable iff (!rst_b)
    ctl.csr_wr && !ctl.hot_reset && ps_wr == 2'h3
    |=> s_reg.power_state_sel == 2'h3 ##1
    (s_reg.power_state_sel == 2'h3 || $past(ctl.csr_wr)
     || $past(ctl.hot_reset));
  endproperty
  a_ps_hot_off: assert property (p_ps_hot_off)
    else $error("hot powered-down write not held");

  property p_ctx_lock;
    @(posedge core_clk) disable iff (!rst_b)
    !ctl.cfg_unlock && !ctl.hot_reset |=> $stable(s_reg.context_kept_flag);
  endproperty
  a_ctx_lock: assert property (p_ctx_lock)
    else $error("context flag changed while locked");
endmodule

// ### hw/wake_ctl.sv
// Wake enable, wake status and outgoing wake message
`timescale 1ns/100ps
`include "pm_regs_defs.svh"
module wake_ctl (
  input wire logic core_clk,
  input wire logic rst_b,
  pm_ctl_if.wake_side ctl
);
  pm_regs_pkg::wake_state_type s_reg;
  pm_regs_pkg::wake_state_type s_next;
  logic own_set;

  // Only an event the port made itself, never in the upstream port
  assign own_set = ctl.own_wake && !ctl.is_upstream;

  // -------------------------------------------------------------------
  // Next state; hot reset leaves all of it alone
  // -------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (ctl.csr_wr) begin
      s_next.wake_enable = ctl.csr_wdata[`WEN_BIT];
      if (ctl.csr_w1c) begin
        s_next.wake_status = 1'b0;
      end
    end
    if (own_set) begin
      s_next.wake_status = 1'b1;
    end
    s_next.wake_msg = own_set && s_reg.wake_enable;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg.wake_enable <= `WEN_RST;
      s_reg.wake_status <= `WST_RST;
      s_reg.wake_msg <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ctl.wake_enable = s_reg.wake_enable;
  assign ctl.wake_status = s_reg.wake_status;
  assign ctl.wake_msg = s_reg.wake_msg;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  property p_msg_gate;
    @(posedge core_clk) disable iff (!rst_b)
    s_reg.wake_msg |-> $past(s_reg.wake_enable) && $past(ctl.own_wake);
  endproperty
  a_msg_gate: assert property (p_msg_gate)
    else $error("wake message without enable");

  property p_status_set;
    @(posedge core_clk) disable iff (!rst_b)
    ctl.own_wake && !ctl.is_upstream |=> s_reg.wake_status;
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("own wake event did not set status");

  property p_upstream;
    @(posedge core_clk) disable iff (!rst_b)
    ctl.is_upstream && !s_reg.wake_status |=> !s_reg.wake_status;
  endproperty
  a_upstream: assert property (p_upstream)
    else $error("upstream port set wake status");

  property p_hot_keep;
    @(posedge core_clk) disable iff (!rst_b)
    ctl.hot_reset && !ctl.csr_wr |=> $stable(s_reg.wake_enable);
  endproperty
  a_hot_keep: assert property (p_hot_keep)
    else $error("hot reset changed wake enable");

  property p_w1c;
    @(posedge core_clk) disable iff (!rst_b)
    ctl.csr_wr && ctl.csr_w1c && !ctl.own_wake |=> !s_reg.wake_status;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear wake status");
endmodule

// ### tb/pci_power_mgmt_capability_regs_tb.sv
// Self-checking bench for the power-management register block
`timescale 1ns/100ps
`include "pm_regs_defs.svh"
module pci_power_mgmt_capability_regs_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic awvalid = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic wvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic bready = 1'b1;
  logic arvalid = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic rready = 1'b1;
  logic hot_reset = 1'b0;
  logic cfg_unlock = 1'b0;
  logic is_upstream = 1'b0;
  logic own_wake = 1'b0;
  logic awready;
  logic wready;
  logic bvalid;
  logic [1:0] bresp;
  logic arready;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic wake_msg;
  logic hot_off_state;
  logic context_kept;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int msg_count = 0;
  int base = 0;
  logic [31:0] rd_val;
  logic [1:0] resp;

  pm_cap_regs uut (
    .core_clk(core_clk), .rst_b(rst_b),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .hot_reset(hot_reset), .cfg_unlock(cfg_unlock),
    .is_upstream(is_upstream), .own_wake(own_wake),
    .wake_msg(wake_msg), .hot_off_state(hot_off_state),
    .context_kept(context_kept)
  );

  // ------------------------------------------------------------
  // Clock, watchdog and wake pulse counter
  // ------------------------------------------------------------
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (wake_msg === 1'b1) begin
      msg_count++;
    end
    if (cycles >= 5000) begin
      $display("Error at %0t: timeout got %h expected %h", $time, cycles, 0);
      mismatches++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (!aw_done && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask

  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge core_clk);
    rd_val = rdata;
    resp = rresp;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    check(rd_val, exp);
    check({30'h0, resp}, {30'h0, `RESP_OKAY});
  endtask

  task automatic wake_pulse;
    base = msg_count;
    own_wake <= 1'b1;
    @(posedge core_clk);
    own_wake <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    // Reset values
    rchk(`PM_CAP_OFF, 32'hc9c00000);
    rchk(`PM_CSR_OFF, 32'h00000008);
    check({30'h0, hot_off_state, context_kept}, 32'h1);
    // Capability word
    wr(`PM_CAP_OFF, 32'hffffffff, 4'hf);
    check({30'h0, resp}, {30'h0, `RESP_OKAY});
    rchk(`PM_CAP_OFF, 32'hf9c00000);
    wr(`PM_CAP_OFF, 32'h00c00000, 4'hf);
    rchk(`PM_CAP_OFF, 32'h00c00000);
    // Power state and reserved codes
    wr(`PM_CSR_OFF, 32'h00000003, 4'hf);
    rchk(`PM_CSR_OFF, 32'h0000000b);
    check({31'h0, hot_off_state}, 32'h1);
    for (int i = 1; i < 3; i++) begin
      wr(`PM_CSR_OFF, 32'(i), 4'hf);
      rchk(`PM_CSR_OFF, 32'h0000000b);
    end
    wr(`PM_CSR_OFF, 32'h00000000, 4'hf);
    rchk(`PM_CSR_OFF, 32'h00000008);
    // Context flag under unlock
    cfg_unlock <= 1'b1;
    wr(`PM_CSR_OFF, 32'h00000000, 4'hf);
    cfg_unlock <= 1'b0;
    rchk(`PM_CSR_OFF, 32'h00000000);
    check({31'h0, context_kept}, 32'h0);
    // Read-only fields ignore writes
    wr(`PM_CSR_OFF, 32'hffff7efc, 4'hf);
    rchk(`PM_CSR_OFF, 32'h00000000);
    // Wake with enable set
    wr(`PM_CSR_OFF, 32'h00000100, 4'hf);
    wake_pulse();
    check(32'(msg_count - base), 32'h1);
    rchk(`PM_CSR_OFF, 32'h00008100);
    wr(`PM_CSR_OFF, 32'h00008100, 4'h1);
    rchk(`PM_CSR_OFF, 32'h00008100);
    wr(`PM_CSR_OFF, 32'h00008100, 4'hf);
    rchk(`PM_CSR_OFF, 32'h00000100);
    // Wake with enable clear
    wr(`PM_CSR_OFF, 32'h00000000, 4'hf);
    wake_pulse();
    check(32'(msg_count - base), 32'h0);
    rchk(`PM_CSR_OFF, 32'h00008000);
    wr(`PM_CSR_OFF, 32'h00008000, 4'hf);
    rchk(`PM_CSR_OFF, 32'h00000000);
    // Upstream port never flags a wake
    is_upstream <= 1'b1;
    wr(`PM_CSR_OFF, 32'h00000100, 4'hf);
    wake_pulse();
    check(32'(msg_count - base), 32'h0);
    rchk(`PM_CSR_OFF, 32'h00000100);
    is_upstream <= 1'b0;
    // Hot reset keeps sticky fields
    wr(`PM_CSR_OFF, 32'h00000103, 4'hf);
    wake_pulse();
    hot_reset <= 1'b1;
    @(posedge core_clk);
    hot_reset <= 1'b0;
    @(posedge core_clk);
    rchk(`PM_CSR_OFF, 32'h00008108);
    rchk(`PM_CAP_OFF, 32'h00c00000);
    check({30'h0, hot_off_state, context_kept}, 32'h1);
    // Unmapped address
    rd(12'h0c8);
    check(rd_val, 32'h00000000);
    check({30'h0, resp}, {30'h0, `RESP_SLVERR});
    wr(12'h0c8, 32'hffffffff, 4'hf);
    check({30'h0, resp}, {30'h0, `RESP_SLVERR});
    rchk(`PM_CSR_OFF, 32'h00008108);
    // Fundamental reset in mid-run
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rchk(`PM_CAP_OFF, 32'hc9c00000);
    rchk(`PM_CSR_OFF, 32'h00000008);
    print_verdict();
  end
endmodule
